// [logic/itf_timing.v]
// Purpose: cycle count and flag effects for integer instructions AAA..BTC
// Assumes: one instruction offered per issue pulse, inputs synchronous
// Notes: counts in core clocks; results held until next issue, done follows issue one clock later
`timescale 1ns/1ns
`default_nettype none
`include "itf_map.vh"
module itf_timing (
    // clock and reset
    input wire clock,
    input wire resetn,
    // instruction in
    input wire issue,
    input wire [7:0] op0,
    input wire [7:0] op1,
    input wire [7:0] op2,
    // execution context
    input wire prot_mode,
    input wire two_reg_ea,
    input wire misaligned,
    input wire rmw_access,
    input wire uncached,
    input wire lock_prefix,
    input wire core_ratio_3x,
    input wire bound_out,
    input wire [3:0] aam_extra,
    input wire [7:0] int_cost,
    // results
    output reg done,
    output reg [7:0] cycles_q,
    output reg [26:0] flag_act_q,
    output reg [4:0] class_q,
    output reg invalid_q,
    output reg trap5_q
);
    // -------------------------------------------------------------
    // decode and flag table
    // -------------------------------------------------------------
    wire [4:0] iclass; // decoded class
    wire imm_form; // immediate form
    wire mem_form; // memory operand
    wire [26:0] actions; // flag actions
    itf_decode u_dec (
        .op0(op0),
        .op1(op1),
        .op2(op2),
        .iclass(iclass),
        .imm_form(imm_form),
        .mem_form(mem_form)
    );
    itf_flags u_flg (
        .iclass(iclass),
        .actions(actions)
    );
    // -------------------------------------------------------------
    // base count
    // -------------------------------------------------------------
    reg [7:0] base; // core clocks before penalties
    reg bad; // not valid in this mode
    reg [7:0] aam_cyc; // clamped aam count
    always @* begin
        base = 8'h00;
        bad = 1'b0;
        // data dependent part, capped at the documented top
        aam_cyc = `ITF_CYC_AAM_MIN + {4'h0, aam_extra};
        if (aam_cyc > `ITF_CYC_AAM_MAX) begin
            aam_cyc = `ITF_CYC_AAM_MAX;
        end
        case (iclass)
            `ITF_C_AAA: base = `ITF_CYC_ASCII;
            `ITF_C_AAS: base = `ITF_CYC_ASCII;
            `ITF_C_AAD: base = `ITF_CYC_ASCII;
            `ITF_C_AAM: base = aam_cyc;
            `ITF_C_ADC: base = `ITF_CYC_ALU;
            `ITF_C_ADD: base = `ITF_CYC_ALU;
            `ITF_C_AND: base = `ITF_CYC_ALU;
            `ITF_C_ARPL: begin
                // real mode: refused
                bad = ~prot_mode;
                base = prot_mode ? `ITF_CYC_ARPL : 8'h00;
            end
            `ITF_C_BOUND: begin
                // out of range adds trap cost in protected mode
                if (bound_out) begin
                    base = `ITF_CYC_BND_OUT + (prot_mode ? int_cost : 8'h00);
                end else begin
                    base = `ITF_CYC_BND_IN;
                end
            end
            `ITF_C_BT: begin
                if (imm_form) begin
                    base = `ITF_CYC_BT_IMM;
                end else begin
                    base = mem_form ? `ITF_CYC_BIT_MEM : `ITF_CYC_BIT_REG;
                end
            end
            `ITF_C_BTC: begin
                if (imm_form) begin
                    base = `ITF_CYC_BTC_IMM;
                end else begin
                    base = mem_form ? `ITF_CYC_BIT_MEM : `ITF_CYC_BIT_REG;
                end
            end
            default: bad = 1'b1;
        endcase
    end
    // -------------------------------------------------------------
    // penalties
    // -------------------------------------------------------------
    wire [7:0] pen_ea = two_reg_ea ? `ITF_PEN_TWO_REG : 8'h00;
    wire [7:0] pen_mis = ~misaligned ? 8'h00 :
        (rmw_access ? `ITF_PEN_MIS_RMW : `ITF_PEN_MIS_ONE);
    wire [7:0] pen_nc_amt = core_ratio_3x ? `ITF_PEN_NC_3X : `ITF_PEN_NC_2X;
    wire pay_nc = uncached | lock_prefix; // locked cycles bypass cache
    wire [7:0] pen_nc = pay_nc ? pen_nc_amt : 8'h00;
    wire [7:0] total = base + pen_ea + pen_mis + pen_nc;
    // -------------------------------------------------------------
    // result registers
    // -------------------------------------------------------------
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            done <= 1'b0;
            cycles_q <= 8'h00;
            flag_act_q <= {27{1'b0}};
            class_q <= 5'h00;
            invalid_q <= 1'b0;
            trap5_q <= 1'b0;
        end else begin
            done <= issue;
            if (issue) begin
                class_q <= iclass;
                invalid_q <= bad;
                cycles_q <= bad ? 8'h00 : total;
                flag_act_q <= bad ? {27{1'b0}} : actions;
                trap5_q <= (iclass == `ITF_C_BOUND) & bound_out;
            end
        end
    end
endmodule // itf_timing
`default_nettype wire

// [logic/itf_map.vh]
// Purpose: constants for the integer instruction timing and flag decoder
// Assumes: included by bare name from the design files
// Notes: definitions only
`ifndef ITF_MAP_VH
`define ITF_MAP_VH
// flag actions, 3 bits each
`define ITF_ACT_KEEP 3'h0
`define ITF_ACT_MOD 3'h1
`define ITF_ACT_CLR 3'h2
`define ITF_ACT_SET 3'h3
`define ITF_ACT_UND 3'h4
// flag slots in the 27-bit action vector, slot times three
`define ITF_F_OF 0
`define ITF_F_DF 1
`define ITF_F_IF 2
`define ITF_F_TF 3
`define ITF_F_SF 4
`define ITF_F_ZF 5
`define ITF_F_AF 6
`define ITF_F_PF 7
`define ITF_F_CF 8
`define ITF_NFLAGS 9
// instruction classes
`define ITF_C_NONE 5'h00
`define ITF_C_AAA 5'h01
`define ITF_C_AAD 5'h02
`define ITF_C_AAM 5'h03
`define ITF_C_AAS 5'h04
`define ITF_C_ADC 5'h05
`define ITF_C_ADD 5'h06
`define ITF_C_AND 5'h07
`define ITF_C_ARPL 5'h08
`define ITF_C_BOUND 5'h09
`define ITF_C_BT 5'h0a
`define ITF_C_BTC 5'h0b
// base counts in core clocks
`define ITF_CYC_ASCII 8'h07
`define ITF_CYC_AAM_MIN 8'h0d
`define ITF_CYC_AAM_MAX 8'h15
`define ITF_CYC_ALU 8'h01
`define ITF_CYC_ARPL 8'h09
`define ITF_CYC_BND_IN 8'h0b
`define ITF_CYC_BND_OUT 8'h14
`define ITF_CYC_BT_IMM 8'h02
`define ITF_CYC_BTC_IMM 8'h03
`define ITF_CYC_BIT_REG 8'h05
`define ITF_CYC_BIT_MEM 8'h06
// penalties in core clocks
`define ITF_PEN_TWO_REG 8'h01
`define ITF_PEN_MIS_ONE 8'h01
`define ITF_PEN_MIS_RMW 8'h02
`define ITF_PEN_NC_2X 8'h02
`define ITF_PEN_NC_3X 8'h04
// opcode bytes
`define ITF_OP_AAA 8'h37
`define ITF_OP_AAS 8'h3f
`define ITF_OP_AAD 8'hd5
`define ITF_OP_AAM 8'hd4
`define ITF_OP_BASE10 8'h0a
`define ITF_OP_ARPL 8'h63
`define ITF_OP_BOUND 8'h62
`define ITF_OP_ESC 8'h0f
`define ITF_OP_BITGRP 8'hba
`define ITF_OP_BT 8'ha3
`define ITF_OP_BTC 8'hbb
`define ITF_OP_IMMGRP 6'h20
`define ITF_REG_ADD 3'h0
`define ITF_REG_ADC 3'h2
`define ITF_REG_AND 3'h4
`define ITF_REG_BT 3'h4
`define ITF_REG_BTC 3'h7
`endif

// [logic/itf_decode.v]
// Purpose: classify one opcode sequence into an instruction class
// Assumes: opcode bytes already aligned, prefixes stripped
// Notes: pure combinational
`timescale 1ns/1ns
`default_nettype none
`include "itf_map.vh"
module itf_decode (
    // opcode bytes
    input wire [7:0] op0,
    input wire [7:0] op1,
    input wire [7:0] op2,
    // result
    output reg [4:0] iclass,
    output reg imm_form,
    output reg mem_form
);
    // -------------------------------------------------------------
    // decode
    // -------------------------------------------------------------
    // modrm follows op0 for one-byte forms, op1 for 0f forms
    wire [2:0] reg1 = op1[5:3];
    wire [2:0] reg2 = op2[5:3];
    always @* begin
        iclass = `ITF_C_NONE;
        imm_form = 1'b0;
        mem_form = 1'b0;
        if (op0 == `ITF_OP_AAA) begin
            iclass = `ITF_C_AAA;
        end else if (op0 == `ITF_OP_AAS) begin
            iclass = `ITF_C_AAS;
        end else if (op0 == `ITF_OP_AAD && op1 == `ITF_OP_BASE10) begin
            iclass = `ITF_C_AAD;
        end else if (op0 == `ITF_OP_AAM && op1 == `ITF_OP_BASE10) begin
            iclass = `ITF_C_AAM;
        end else if (op0 == `ITF_OP_ARPL) begin
            iclass = `ITF_C_ARPL;
        end else if (op0 == `ITF_OP_BOUND) begin
            iclass = `ITF_C_BOUND;
        end else if (op0[7:2] == `ITF_OP_IMMGRP) begin
            // immediate group 8 [00sw]
            imm_form = 1'b1;
            mem_form = (op1[7:6] != 2'h3);
            case (reg1)
                `ITF_REG_ADD: iclass = `ITF_C_ADD;
                `ITF_REG_ADC: iclass = `ITF_C_ADC;
                `ITF_REG_AND: iclass = `ITF_C_AND;
                default: iclass = `ITF_C_NONE;
            endcase
        end else if (op0[7:6] == 2'h0 && op0[2:1] != 2'h3 && op0[3] == 1'b0) begin
            // nibble-coded alu forms: x0..x5
            mem_form = (op0[2] == 1'b0) && (op1[7:6] != 2'h3);
            imm_form = op0[2];
            case (op0[5:4])
                2'h0: iclass = `ITF_C_ADD;
                2'h1: iclass = `ITF_C_ADC;
                2'h2: iclass = `ITF_C_AND;
                default: iclass = `ITF_C_NONE;
            endcase
        end else if (op0 == `ITF_OP_ESC) begin
            mem_form = (op2[7:6] != 2'h3);
            if (op1 == `ITF_OP_BT) begin
                iclass = `ITF_C_BT;
            end else if (op1 == `ITF_OP_BTC) begin
                iclass = `ITF_C_BTC;
            end else if (op1 == `ITF_OP_BITGRP) begin
                imm_form = 1'b1;
                if (reg2 == `ITF_REG_BT) begin
                    iclass = `ITF_C_BT;
                end else if (reg2 == `ITF_REG_BTC) begin
                    iclass = `ITF_C_BTC;
                end
            end
        end
    end
endmodule // itf_decode
`default_nettype wire

// [logic/itf_flags.v]
// Purpose: per-flag action table for one instruction class
// Assumes: class code from itf_decode
// Notes: nine 3-bit action codes packed by flag slot
`timescale 1ns/1ns
`default_nettype none
`include "itf_map.vh"
module itf_flags (
    // class in
    input wire [4:0] iclass,
    // actions out, slot k at bits 3k+2:3k
    output reg [26:0] actions
);
    // -------------------------------------------------------------
    // table
    // -------------------------------------------------------------
    // helper: build a vector from one action each for of, sf, zf, af, pf, cf; other slots keep
    function [26:0] pack;
        input [2:0] o, s, z, a, p, c;
        begin
            pack = {27{1'b0}};
            pack[3*`ITF_F_OF +: 3] = o;
            pack[3*`ITF_F_SF +: 3] = s;
            pack[3*`ITF_F_ZF +: 3] = z;
            pack[3*`ITF_F_AF +: 3] = a;
            pack[3*`ITF_F_PF +: 3] = p;
            pack[3*`ITF_F_CF +: 3] = c;
        end
    endfunction
    // df, if, tf stay unchanged for all classes here
    always @* begin
        case (iclass)
            `ITF_C_AAA, `ITF_C_AAS: actions = pack(`ITF_ACT_UND, `ITF_ACT_UND,
                `ITF_ACT_UND, `ITF_ACT_MOD, `ITF_ACT_UND, `ITF_ACT_MOD);
            `ITF_C_AAD, `ITF_C_AAM: actions = pack(`ITF_ACT_UND, `ITF_ACT_MOD,
                `ITF_ACT_MOD, `ITF_ACT_UND, `ITF_ACT_MOD, `ITF_ACT_UND);
            `ITF_C_ADC, `ITF_C_ADD: actions = pack(`ITF_ACT_MOD, `ITF_ACT_MOD,
                `ITF_ACT_MOD, `ITF_ACT_MOD, `ITF_ACT_MOD, `ITF_ACT_MOD);
            `ITF_C_AND: actions = pack(`ITF_ACT_CLR, `ITF_ACT_MOD,
                `ITF_ACT_MOD, `ITF_ACT_UND, `ITF_ACT_MOD, `ITF_ACT_CLR);
            `ITF_C_ARPL: actions = pack(`ITF_ACT_KEEP, `ITF_ACT_KEEP,
                `ITF_ACT_MOD, `ITF_ACT_KEEP, `ITF_ACT_KEEP, `ITF_ACT_KEEP);
            `ITF_C_BT, `ITF_C_BTC: actions = pack(`ITF_ACT_KEEP, `ITF_ACT_KEEP,
                `ITF_ACT_KEEP, `ITF_ACT_KEEP, `ITF_ACT_KEEP, `ITF_ACT_MOD);
            default: actions = {27{1'b0}};
        endcase
    end
endmodule // itf_flags
`default_nettype wire

// [verification/itf_timing_props.sv]
// Purpose: port checks for the instruction timing and flag decoder
// Assumes: bound to itf_timing, one clock domain
// Notes: penalty-free issues pin exact counts, except aam which is checked only against its range
`timescale 1ns/1ns
`default_nettype none
module itf_timing_props (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // instruction in
    input wire logic issue,
    input wire logic [7:0] op0,
    input wire logic [7:0] op1,
    // context
    input wire logic prot_mode,
    input wire logic two_reg_ea,
    input wire logic misaligned,
    input wire logic uncached,
    input wire logic lock_prefix,
    input wire logic core_ratio_3x,
    input wire logic bound_out,
    // results
    input wire logic [7:0] cycles_q,
    input wire logic [26:0] flag_act_q,
    input wire logic invalid_q,
    input wire logic trap5_q
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    // issue with no penalty condition raised
    sequence s_clean;
        issue && !two_reg_ea && !misaligned && !uncached && !lock_prefix;
    endsequence
    // add opcode 03 with the lock prefix, no two-register or misaligned penalty
    sequence s_lock_add;
        issue && op0 == 8'h03 && lock_prefix && !two_reg_ea && !misaligned;
    endsequence
    a_ascii_add: assert property (s_clean ##0 op0 == 8'h37 |=>
        cycles_q == 8'h07 && flag_act_q == 27'h1864004) else $error("add adjust wrong");
    a_ascii_sub: assert property (s_clean ##0 op0 == 8'h3f |=>
        cycles_q == 8'h07 && flag_act_q == 27'h1864004) else $error("sub adjust wrong");
    a_aam_range: assert property (s_clean ##0 op0 == 8'hd4 && op1 == 8'h0a |=>
        cycles_q inside {[8'h0d:8'h15]}) else $error("mul adjust out of range");
    a_and_flags: assert property (issue && op0 == 8'h25 |=>
        flag_act_q == 27'h2309002) else $error("and flags wrong");
    a_ea_penalty: assert property (issue && op0 == 8'h03 && op1[7:6] != 2'h3
        && two_reg_ea && !misaligned && !uncached && !lock_prefix |=> cycles_q == 8'h02)
        else $error("two register address cost wrong");
    a_lock_cost: assert property (s_lock_add |=>
        cycles_q == ($past(core_ratio_3x) ? 8'h05 : 8'h03)) else $error("lock cost wrong");
    a_priv_real: assert property (issue && op0 == 8'h63 && !prot_mode |=>
        invalid_q && cycles_q == 8'h00) else $error("privilege adjust taken in real mode");
    a_bound_trap: assert property (s_clean ##0 op0 == 8'h62 && !prot_mode |=>
        trap5_q == $past(bound_out) && cycles_q == ($past(bound_out) ? 8'h14 : 8'h0b))
        else $error("bound check wrong");
endmodule // itf_timing_props
bind itf_timing itf_timing_props i_props (.clock, .resetn, .issue, .op0, .op1, .prot_mode,
    .two_reg_ea, .misaligned, .uncached, .lock_prefix, .core_ratio_3x, .bound_out,
    .cycles_q, .flag_act_q, .invalid_q, .trap5_q);
`default_nettype wire

// [verification/integer_instr_timing_flags_tb_top.sv]
// Purpose: directed bench for the instruction timing and flag decoder
// Assumes: inputs driven on the falling edge, issue held between calls
// Notes: flag vectors packed cf..of, slot 0 lowest
`timescale 1ns/1ns
`default_nettype none
module integer_instr_timing_flags_tb_top;
    // ----------------------------------------
    // stimulus and results
    // ----------------------------------------
    reg clock = 1'h0, resetn = 1'h0, issue = 1'h0, prot_mode = 1'h0;
    reg two_reg_ea = 1'h0, misaligned = 1'h0, rmw_access = 1'h0, uncached = 1'h0;
    reg lock_prefix = 1'h0, core_ratio_3x = 1'h0, bound_out = 1'h0;
    reg [7:0] op0 = 8'h00, op1 = 8'h00, op2 = 8'h00, int_cost = 8'h00;
    reg [3:0] aam_extra = 4'h0;
    wire done, invalid_q, trap5_q;
    wire [7:0] cycles_q;
    wire [26:0] flag_act_q;
    wire [4:0] class_q;
    integer fails = 0, samples_checked = 0;
    // expected flag actions: 1 modify, 2 clear, 4 undefined, 0 keep
    localparam [26:0] fl_aaa = {3'h1, 3'h4, 3'h1, 3'h4, 3'h4, 9'h0, 3'h4};
    localparam [26:0] fl_aad = {3'h4, 3'h1, 3'h4, 3'h1, 3'h1, 9'h0, 3'h4};
    localparam [26:0] fl_alu = {3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 9'h0, 3'h1};
    localparam [26:0] fl_and = {3'h2, 3'h1, 3'h4, 3'h1, 3'h1, 9'h0, 3'h2};
    localparam [26:0] fl_zf = {9'h0, 3'h1, 15'h0};
    localparam [26:0] fl_cf = {3'h1, 24'h0};
    always #50 clock = ~clock;
    itf_timing i_dut (.clock, .resetn, .issue, .op0, .op1, .op2, .prot_mode, .two_reg_ea,
        .misaligned, .rmw_access, .uncached, .lock_prefix, .core_ratio_3x, .bound_out,
        .aam_extra, .int_cost, .done, .cycles_q, .flag_act_q, .class_q, .invalid_q, .trap5_q);
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("unexpected %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    // one instruction per cycle, answer read one cycle later
    task t(input [7:0] a, b, c, input [4:0] k, input [7:0] n, input [26:0] fl);
        begin
            op0 = a;
            op1 = b;
            op2 = c;
            issue = 1'h1;
            @(negedge clock);
            chk("done", done, 1'h1);
            chk("class", class_q, k);
            chk("cycles", cycles_q, n);
            chk("flags", flag_act_q, fl);
            // unknown opcodes, and privilege adjust outside protected mode, are refused
            chk("invalid", invalid_q, k == 5'h00 || (k == 5'h08 && !prot_mode));
            chk("trap", trap5_q, k == 5'h09 && bound_out);
        end
    endtask
    // memory add used as the carrier for penalties
    task p(input [7:0] n);
        t(8'h03, 8'h00, 8'h00, 5'h06, n, fl_alu);
    endtask
    // drop issue, done must fall
    task idle(input string nm);
        begin
            issue = 1'h0;
            @(negedge clock);
            chk("done idle", done, 1'h0);
            $display("test %s done", nm);
        end
    endtask
    task final_report;
        begin
            $display("checks %0d mismatches %0d", samples_checked, fails);
            if (fails == 0 && samples_checked > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (500) @(posedge clock);
        fails = fails + 1;
        final_report;
    end
    initial begin
        repeat (12) @(negedge clock);
        chk("reset cycles", cycles_q, 8'h00);
        resetn = 1'h1;
        t(8'h37, 8'h00, 8'h00, 5'h01, 8'h07, fl_aaa);
        t(8'h3f, 8'h00, 8'h00, 5'h04, 8'h07, fl_aaa);
        t(8'hd5, 8'h0a, 8'h00, 5'h02, 8'h07, fl_aad);
        t(8'hd4, 8'h0a, 8'h00, 5'h03, 8'h0d, fl_aad);
        aam_extra = 4'h5;
        t(8'hd4, 8'h0a, 8'h00, 5'h03, 8'h12, fl_aad);
        aam_extra = 4'hf;
        t(8'hd4, 8'h0a, 8'h00, 5'h03, 8'h15, fl_aad);
        t(8'h10, 8'hc0, 8'h00, 5'h05, 8'h01, fl_alu);
        t(8'h81, 8'hd0, 8'h00, 5'h05, 8'h01, fl_alu);
        t(8'h00, 8'hc0, 8'h00, 5'h06, 8'h01, fl_alu);
        t(8'h83, 8'hc0, 8'h00, 5'h06, 8'h01, fl_alu);
        t(8'h25, 8'h00, 8'h00, 5'h07, 8'h01, fl_and);
        t(8'h80, 8'he0, 8'h00, 5'h07, 8'h01, fl_and);
        t(8'h81, 8'hc8, 8'h00, 5'h00, 8'h00, 27'h0);
        idle("decode");
        t(8'h63, 8'hc0, 8'h00, 5'h08, 8'h00, 27'h0);
        prot_mode = 1'h1;
        t(8'h63, 8'hc0, 8'h00, 5'h08, 8'h09, fl_zf);
        prot_mode = 1'h0;
        t(8'h62, 8'h00, 8'h00, 5'h09, 8'h0b, 27'h0);
        bound_out = 1'h1;
        t(8'h62, 8'h00, 8'h00, 5'h09, 8'h14, 27'h0);
        prot_mode = 1'h1;
        int_cost = 8'h20;
        t(8'h62, 8'h00, 8'h00, 5'h09, 8'h34, 27'h0);
        prot_mode = 1'h0;
        bound_out = 1'h0;
        t(8'h0f, 8'hba, 8'he0, 5'h0a, 8'h02, fl_cf);
        t(8'h0f, 8'ha3, 8'hc0, 5'h0a, 8'h05, fl_cf);
        t(8'h0f, 8'ha3, 8'h00, 5'h0a, 8'h06, fl_cf);
        t(8'h0f, 8'hba, 8'hf8, 5'h0b, 8'h03, fl_cf);
        t(8'h0f, 8'hbb, 8'hc0, 5'h0b, 8'h05, fl_cf);
        t(8'h0f, 8'hbb, 8'h00, 5'h0b, 8'h06, fl_cf);
        idle("system");
        two_reg_ea = 1'h1;
        p(8'h02);
        two_reg_ea = 1'h0;
        misaligned = 1'h1;
        p(8'h02);
        rmw_access = 1'h1;
        p(8'h03);
        misaligned = 1'h0;
        uncached = 1'h1;
        p(8'h03);
        core_ratio_3x = 1'h1;
        p(8'h05);
        uncached = 1'h0;
        lock_prefix = 1'h1;
        p(8'h05);
        core_ratio_3x = 1'h0;
        uncached = 1'h1;
        p(8'h03);
        lock_prefix = 1'h0;
        two_reg_ea = 1'h1;
        misaligned = 1'h1;
        core_ratio_3x = 1'h1;
        p(8'h08);
        idle("penalty");
        resetn = 1'h0;
        @(negedge clock);
        chk("reset again", cycles_q, 8'h00);
        final_report;
    end
endmodule // integer_instr_timing_flags_tb_top
`default_nettype wire
